// ==== sram_access_pkg.sv ====
// Package with widths, encodings and pin groups of the burst memory access control.
package sram_access_pkg;

  // Organisation: each byte lane carries eight data bits and one parity bit.
  localparam int LANE_DATA_W = 8;
  localparam int LANE_W = LANE_DATA_W + 1;
  localparam int DEFAULT_LANES = 4;
  localparam int DEFAULT_ADDR_W = 18;

  // Burst counter layout: the two lowest address bits wrap inside a block.
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;

  // Burst order select level that picks the linear sequence.
  localparam logic ORDER_LINEAR = 1'h0;

  // Sleep entry and exit both take this many clock cycles.
  localparam int SLEEP_CYCLES = 2;

  // Synchronous control pins sampled at each rising clock edge.
  typedef struct packed {
    logic chipEnableFirstN;
    logic chipEnableSecond;
    logic chipEnableThirdN;
    logic processorAddrStrobeN;
    logic controllerAddrStrobeN;
    logic burstAdvanceN;
    logic globalWriteN;
    logic byteWriteGateN;
  } ctrl_pins_t;

  // Access controller states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_BURST = 3'h2,
    ST_SLEEP = 3'h4
  } ctrl_state_t;

endpackage

// ==== sync_burst_sram_access_ctrl.sv ====
// Device-side access control and storage of a pipelined synchronous burst memory.
`timescale 1ns/100ps

module sync_burst_sram_access_ctrl
  import sram_access_pkg::*;
#(
  parameter int ADDR_W = DEFAULT_ADDR_W,
  parameter int LANES = DEFAULT_LANES
) (
  // Clock and synchronous reset.
  input wire logic clk,
  input wire logic reset_n,
  // Synchronous control and address pins.
  input wire ctrl_pins_t ctrlPins,
  input wire logic [LANES-1:0] byteLaneWriteN,
  input wire logic [ADDR_W-1:0] address,
  input wire logic burstOrderSelect,
  input wire logic outputEnableN,
  // Sleep request, asynchronous.
  input wire logic sleepRequest,
  // Common data pins, data and parity per lane, split into three signals.
  input wire logic [LANES*LANE_W-1:0] dataIn,
  output logic [LANES*LANE_W-1:0] dataOut,
  output logic dataOe,
  // Status.
  output logic asleep,
  output ctrl_state_t state
);

  localparam int WORD_W = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // Low address bits of a burst step, in the order the select pin picks.
  function automatic logic [BURST_W-1:0] burstLow(input logic [BURST_W-1:0] start,
                                                  input logic [BURST_W-1:0] count,
                                                  input logic orderSel);
    if (orderSel == ORDER_LINEAR) begin
      burstLow = BURST_W'(start + count);
    end else begin
      burstLow = start ^ count;
    end
  endfunction

  // Replaces only the enabled lanes of a stored word, parity included.
  function automatic logic [WORD_W-1:0] mergeLanes(input logic [WORD_W-1:0] oldWord,
                                                   input logic [WORD_W-1:0] newWord,
                                                   input logic [LANES-1:0] mask);
    mergeLanes = oldWord;
    for (int i = 0; i < LANES; i++) begin
      if (mask[i]) begin
        mergeLanes[i*LANE_W +: LANE_W] = newWord[i*LANE_W +: LANE_W];
      end
    end
  endfunction

  // Storage in flip-flops; never reset, so sleep leaves it untouched.
  logic [WORD_W-1:0] mem [0:DEPTH-1];

  // Burst tracking state.
  logic [ADDR_W-BURST_W-1:0] upperAddr;
  logic [BURST_W-1:0] burstStart;
  logic [BURST_W-1:0] burstCount;
  logic sleepMeta;
  ctrl_state_t next_state;

  // Helper registers that only the checks below read.
  logic [BURST_W-1:0] lastLow;
  logic [ADDR_W-1:0] lastAddr;

  // Chip select and strobe decode.
  wire logic allEnabled = !ctrlPins.chipEnableFirstN && ctrlPins.chipEnableSecond &&
                          !ctrlPins.chipEnableThirdN;
  wire logic procStrobe = !ctrlPins.processorAddrStrobeN && !ctrlPins.chipEnableFirstN;
  wire logic ctrlStrobe = !ctrlPins.controllerAddrStrobeN;
  wire logic procBegin = procStrobe && allEnabled;
  wire logic ctrlBegin = ctrlStrobe && !procStrobe && allEnabled;
  wire logic deselect = (procStrobe || ctrlStrobe) && !allEnabled;
  wire logic beginBurst = procBegin || ctrlBegin;
  wire logic noStrobe = !procStrobe && !ctrlStrobe;
  wire logic advance = !ctrlPins.burstAdvanceN;

  // Byte-lane write decode; global write overrides the lane enables.
  wire logic [LANES-1:0] laneMask = !ctrlPins.globalWriteN ? {LANES{1'h1}} :
                                    (!ctrlPins.byteWriteGateN ? ~byteLaneWriteN :
                                     {LANES{1'h0}});
  wire logic writeAny = |laneMask;

  // The processor strobe always starts a read, whatever the write pins say.
  wire logic isWrite = !procBegin && writeAny;
  wire logic inBurst = (state == ST_BURST) && noStrobe;
  wire logic access = !asleep && (beginBurst || inBurst);
  wire logic stepBurst = inBurst && advance;

  // Access address: external on a begin, otherwise next or current counter address.
  wire logic [BURST_W-1:0] nextCount = BURST_W'(burstCount + BURST_STEP);
  wire logic [BURST_W-1:0] curCount = stepBurst ? nextCount : burstCount;
  wire logic [BURST_W-1:0] accLow = beginBurst ? address[BURST_W-1:0] :
                                    burstLow(burstStart, curCount, burstOrderSelect);
  wire logic [ADDR_W-1:0] accAddr = beginBurst ? address : {upperAddr, accLow};
  wire logic [WORD_W-1:0] readWord = mem[accAddr];
  wire logic memWrite = access && isWrite;

  // Two-flop synchroniser; entry and exit each cost exactly two edges.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sleepMeta <= 1'h0;
      asleep <= 1'h0;
    end else begin
      sleepMeta <= sleepRequest;
      asleep <= sleepMeta;
    end
  end

  // Controller state; an access caught by sleep entry is simply dropped.
  always_comb begin
    case (state)
      ST_IDLE: begin
        next_state = beginBurst ? ST_BURST : ST_IDLE;
      end
      ST_BURST: begin
        next_state = deselect ? ST_IDLE : ST_BURST;
      end
      ST_SLEEP: begin
        next_state = beginBurst ? ST_BURST : ST_IDLE; // A begin at the first awake edge counts.
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (asleep) begin
      next_state = ST_SLEEP;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Address register and burst counter.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      upperAddr <= '0;
      burstStart <= BURST_ZERO;
      burstCount <= BURST_ZERO;
    end else if (!asleep && beginBurst) begin
      upperAddr <= address[ADDR_W-1:BURST_W];
      burstStart <= address[BURST_W-1:0];
      burstCount <= BURST_ZERO;
    end else if (!asleep && stepBurst) begin
      burstCount <= nextCount;
    end
  end

  // Storage write; no write happens while asleep, which keeps data intact.
  always_ff @(posedge clk) begin
    if (memWrite) begin
      mem[accAddr] <= mergeLanes(readWord, dataIn, laneMask);
    end
  end

  // Pipelined read data and output enable, both registered.
  // Output enable is sampled here so the pin drive comes from a flop; a write
  // cycle masks it, which protects the bus while the controller drives data.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dataOut <= '0;
      dataOe <= 1'h0;
      lastLow <= BURST_ZERO;
      lastAddr <= '0;
    end else begin
      dataOut <= (access && !isWrite) ? readWord : dataOut;
      dataOe <= access && !isWrite && !outputEnableN;
      lastLow <= access ? accLow : lastLow;
      lastAddr <= access ? accAddr : lastAddr;
    end
  end

  // Linear order: a stepped access lands one above the previous one.
  property p_linear_step;
    @(posedge clk) disable iff (!reset_n)
      (access && stepBurst && burstOrderSelect == ORDER_LINEAR) |->
        accLow == BURST_W'(lastLow + BURST_STEP);
  endproperty
  a_linear_step: assert property (p_linear_step)
    else $error("Linear burst did not step by one.");

  // Interleaved order: two successive steps differ by the XOR of their counts.
  property p_interleave_step;
    @(posedge clk) disable iff (!reset_n)
      (access && stepBurst && burstOrderSelect != ORDER_LINEAR) |->
        (accLow ^ lastLow) == (nextCount ^ burstCount);
  endproperty
  a_interleave_step: assert property (p_interleave_step)
    else $error("Interleaved burst took a wrong address.");

  // Suspend keeps the current address.
  property p_suspend_hold;
    @(posedge clk) disable iff (!reset_n)
      (access && inBurst && !advance) |-> accAddr == lastAddr;
  endproperty
  a_suspend_hold: assert property (p_suspend_hold)
    else $error("Suspended burst moved its address.");

  // The counter moves by one on an advance and not otherwise.
  property p_counter_advance;
    @(posedge clk) disable iff (!reset_n)
      (!asleep && inBurst) |=>
        burstCount == ($past(advance) ? BURST_W'($past(burstCount) + BURST_STEP)
                                      : $past(burstCount));
  endproperty
  a_counter_advance: assert property (p_counter_advance)
    else $error("Burst counter ignored the advance input.");

  // Sleep shows at the second edge after the one that sees the request rise.
  // Only the second synchroniser flop may read the first, so this check uses pins only.
  property p_sleep_entry;
    @(posedge clk) disable iff (!reset_n)
      ($rose(sleepRequest) && !asleep) |-> !asleep ##1 !asleep ##1 asleep;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("Sleep entry did not take two cycles.");

  // Asleep means undriven data pins on the following cycle.
  property p_sleep_quiet;
    @(posedge clk) disable iff (!reset_n)
      asleep |=> !dataOe && state == ST_SLEEP;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("Data pins driven while asleep.");

  // Any begin while awake opens a burst, also on the first edge after wake-up.
  property p_begin_state;
    @(posedge clk) disable iff (!reset_n)
      (!asleep && beginBurst) |=> state == ST_BURST;
  endproperty
  a_begin_state: assert property (p_begin_state)
    else $error("A begin cycle did not open a burst.");

  // Continued and suspended writes never drive the data pins.
  property p_write_quiet;
    @(posedge clk) disable iff (!reset_n)
      (access && inBurst && writeAny) |=> !dataOe;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("Data pins driven during a burst write.");

  // A processor strobe begin is a read whose data appears one cycle later.
  property p_begin_read;
    @(posedge clk) disable iff (!reset_n)
      (!asleep && procBegin) |=>
        state == ST_BURST && dataOut == $past(readWord) && dataOe == !$past(outputEnableN);
  endproperty
  a_begin_read: assert property (p_begin_read)
    else $error("Processor strobe did not begin a read.");

  // Controller strobe with write stores the data and never drives the pins.
  property p_begin_write;
    @(posedge clk) disable iff (!reset_n)
      (!asleep && ctrlBegin && !ctrlPins.globalWriteN) |=>
        !dataOe && mem[$past(address)] == $past(dataIn);
  endproperty
  a_begin_write: assert property (p_begin_write)
    else $error("Burst write did not store all lanes.");

  // A lane write leaves the disabled lanes of the word unchanged.
  property p_lane_keep;
    @(posedge clk) disable iff (!reset_n)
      (memWrite && ctrlPins.globalWriteN) |=>
        mergeLanes(mem[$past(accAddr)], $past(readWord), ~$past(laneMask)) ==
          mem[$past(accAddr)];
  endproperty
  a_lane_keep: assert property (p_lane_keep)
    else $error("A disabled byte lane was written.");

  // Continued reads drive only while output enable was low.
  property p_continue_read;
    @(posedge clk) disable iff (!reset_n)
      (access && inBurst && !isWrite) |=> dataOe == !$past(outputEnableN);
  endproperty
  a_continue_read: assert property (p_continue_read)
    else $error("Continued read drove data against output enable.");

endmodule

// ==== bus_master_model.sv ====
// Behavioural memory controller that drives the synchronous pins of the burst memory.
`timescale 1ns/100ps

module bus_master_model
  import sram_access_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Pins towards the memory.
  output ctrl_pins_t ctrlPins,
  output logic [3:0] byteLaneWriteN,
  output logic [3:0] address,
  output logic [35:0] dataIn,
  output logic burstOrderSelect,
  output logic outputEnableN,
  output logic sleepRequest
);
  // Pins start deselected and awake, so the first access after reset is legal.
  initial begin
    ctrlPins = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1};
    byteLaneWriteN = 4'hF;
    address = 4'h0;
    dataIn = 36'h0;
    burstOrderSelect = 1'h0;
    outputEnableN = 1'h1;
    sleepRequest = 1'h0;
  end

  // One bus cycle, changed at the falling edge and held through the next rising edge.
  task automatic cyc(input logic ceN, pS, cS, burst_advance_n, gw, byte_write_gate_n, oe, input logic [3:0] lanes, a,
                     input logic [35:0] d);
    @(negedge clk);
    ctrlPins = '{ceN, 1'h1, 1'h0, pS, cS, burst_advance_n, gw, byte_write_gate_n};
    byteLaneWriteN = lanes;
    address = a;
    outputEnableN = oe;
    // An idle data bus toggles, so stale write data can never pass as fresh.
    dataIn = (!gw || !byte_write_gate_n) ? d : ~dataIn;
  endtask

  // Both strobes and the first enable stay inactive.
  task automatic idle();
    cyc(1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 4'hF, 4'h0, 36'h0);
  endtask

  // Entry deselects first; exit leaves the strobes idle through recovery.
  task automatic sleep(input logic level);
    cyc(1'h1, 1'h1, !level, 1'h1, 1'h1, 1'h1, 1'h1, 4'hF, 4'h0, 36'h0);
    idle();
    sleepRequest = level;
  endtask

  // Burst order select, changed in a deselect cycle so no open burst sees it switch.
  // Leaving the last pins in place would repeat the previous access instead.
  task automatic order(input logic o);
    cyc(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 4'hF, 4'h0, 36'h0);
    burstOrderSelect = o;
  endtask
endmodule

// ==== sync_burst_sram_access_ctrl_test.sv ====
// Self-checking bench for the burst memory access control.
`timescale 1ns/100ps

module sync_burst_sram_access_ctrl_test
  import sram_access_pkg::*;
;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  ctrl_pins_t ctrlPins;
  logic [3:0] byteLaneWriteN;
  logic [3:0] address;
  logic [35:0] dataIn;
  logic burstOrderSelect;
  logic outputEnableN;
  logic sleepRequest;
  logic [35:0] dataOut;
  logic dataOe;
  logic asleep;
  ctrl_state_t state;
  logic [35:0] refMem [16];
  logic [35:0] notes [$];
  int failCount = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 32'hD69F;

  // Free-running 4 ns clock.
  always #2 clk = ~clk;

  sync_burst_sram_access_ctrl #(.ADDR_W(4), .LANES(4)) u_sync_burst_sram_access_ctrl (
    .clk(clk), .reset_n(reset_n), .ctrlPins(ctrlPins), .byteLaneWriteN(byteLaneWriteN),
    .address(address), .burstOrderSelect(burstOrderSelect), .outputEnableN(outputEnableN),
    .sleepRequest(sleepRequest), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .asleep(asleep), .state(state));

  bus_master_model u_bus_master_model (
    .clk(clk), .ctrlPins(ctrlPins), .byteLaneWriteN(byteLaneWriteN), .address(address),
    .dataIn(dataIn), .burstOrderSelect(burstOrderSelect), .outputEnableN(outputEnableN),
    .sleepRequest(sleepRequest));

  task automatic check(input logic [35:0] seen, exp, input string msg);
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic final_report();
    $display("counts: %0d checked, %0d failed", checked, failCount);
    if (failCount == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Read with output enable low; pins carry a wrong address unless a strobe is used.
  task automatic rd(input logic ceN, pS, cS, burst_advance_n, gw, byte_write_gate_n, input logic [3:0] lanes, e);
    u_bus_master_model.cyc(ceN, pS, cS, burst_advance_n, gw, byte_write_gate_n, 1'h0, lanes, (pS & cS) ? ~e : e, 36'h0);
    notes.push_back(refMem[e]);
  endtask

  // Write with the lane gate low; the reference image follows the written lanes.
  task automatic wr(input logic cS, burst_advance_n, gw, input logic [3:0] lanes, a, input logic [35:0] d);
    u_bus_master_model.cyc(1'h0, 1'h1, cS, burst_advance_n, gw, 1'h0, 1'h1, lanes, cS ? ~a : a, d);
    for (int i = 0; i < 4; i++) if (!gw || !lanes[i]) refMem[a][9*i +: 9] = d[9*i +: 9];
  endtask

  // Each read drive is paired with the oldest expected word.
  always @(negedge clk) begin
    if (dataOe === 1'h1) begin
      if (notes.size() == 0) check(1'h1, 1'h0, "drive without a read");
      else check(dataOut, notes.pop_front(), "read data");
    end
  end

  // Hang guard; the whole run needs well under this many cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failCount++;
      final_report();
    end
  end

  // Main sequence.
  initial begin
    logic [3:0] base;
    logic [3:0] e;
    logic [35:0] d;
    logic [3:0] lanes;
    repeat (12) @(negedge clk);
    reset_n = 1'h1;
    for (int a = 0; a < 16; a++) begin
      d = 36'({$random(seed), $random(seed)});
      wr(1'h0, 1'h1, 1'h0, 4'h0, 4'(a), d);
    end
    $display("test fill done");
    for (int o = 0; o < 2; o++) begin
      u_bus_master_model.order(o[0]);
      for (int s = 0; s < 4; s++) begin
        base = {2'($random(seed)), 2'(s)};
        // Gate high with any lanes, or gate low with every lane off, must both read.
        lanes = s[1] ? 4'hF : 4'($random(seed));
        if (s[0]) rd(1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 4'h0, base);
        else rd(1'h0, 1'h1, 1'h0, 1'h0, 1'h1, !s[1], lanes, base);
        for (int n = 1; n < 4; n++) begin
          e = {base[3:2], o[0] ? base[1:0] ^ 2'(n) : base[1:0] + 2'(n)};
          rd(n[0], !n[0], 1'h1, 1'h0, 1'h1, 1'h1, 4'h0, e);
        end
        rd(1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 4'h0, e);
      end
    end
    $display("test burst order done");
    u_bus_master_model.order(1'h0);
    for (int k = 0; k < 16; k++) begin
      base = 4'($random(seed));
      e = {base[3:2], base[1:0] + 2'h1};
      d = 36'({$random(seed), $random(seed)});
      wr(1'h0, 1'h0, 1'h0, 4'h0, base, d);
      wr(1'h1, 1'h0, 1'h1, 4'(k), e, ~d);
      wr(1'h1, 1'h1, 1'h1, 4'($random(seed)), e, d ^ 36'h5A5);
      rd(1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 4'h0, base);
      rd(1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 4'h0, e);
    end
    $display("test byte writes done");
    u_bus_master_model.sleep(1'h1);
    u_bus_master_model.idle();
    check(asleep, 1'h0, "sleep entered early");
    u_bus_master_model.idle();
    check(asleep, 1'h1, "sleep not entered");
    u_bus_master_model.cyc(1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 4'h0, 4'h0, 36'h0);
    check(state, ST_SLEEP, "state while asleep");
    u_bus_master_model.cyc(1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 4'h0, 4'h0, ~refMem[0]);
    check(dataOe, 1'h0, "drive while asleep");
    u_bus_master_model.sleep(1'h0);
    u_bus_master_model.idle();
    check(asleep, 1'h1, "sleep left early");
    u_bus_master_model.idle();
    check(asleep, 1'h0, "sleep not left");
    rd(1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 4'h0, 4'h0);
    rd(1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 4'h0, 4'h1);
    u_bus_master_model.idle();
    u_bus_master_model.idle();
    check(36'(notes.size()), 36'h0, "reads never driven");
    $display("test sleep done");
    final_report();
  end
endmodule
